// ### src/sre_pkg.sv
`default_nettype none
package sre_pkg;

  // ----------------------------------------
  // Array and address geometry
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int MEM_BYTES = 65536;
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int PAGE_W = 7;

  // ----------------------------------------
  // Device address word and bit values
  // ----------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic ACK_BIT = 1'b0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TWR_NS = 5000000;
  // Longest time, so rounded down
  localparam int TWR_CYCLES = TWR_NS / CLK_PERIOD_NS;
  localparam int QTR_CYCLES = 8;
  localparam int FIFO_DEPTH = 8;

endpackage : sre_pkg
`default_nettype wire

// ### src/sre_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sre_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire sda;

  // Open-drain wire: any enabled low driver wins
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : sre_if
`default_nettype wire

// ### src/sre_target.sv
`timescale 1ns/10ps
`default_nettype none
module sre_target #(
  parameter int TWR_CYC = sre_pkg::TWR_CYCLES,
  parameter int MEM_BYTES = sre_pkg::MEM_BYTES
) (
  input wire logic clk,
  input wire logic resetn,
  sre_if.dev bus,
  input wire logic [sre_pkg::SEL_W-1:0] chip_select_straps,
  output logic write_busy,
  output logic [sre_pkg::ADDR_W-1:0] word_addr
);
  import sre_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_ACK,
    D_WRX,
    D_TX,
    D_MACK
  } sre_dstate_t;

  localparam int BW = $clog2(TWR_CYC + 1);

  sre_dstate_t state_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [SEL_W-1:0] sel_meta_q;
  logic [SEL_W-1:0] sel_q;
  logic [3:0] bit_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] hi_q;
  logic [1:0] byte_idx_q;
  logic rw_q;
  logic oe_q;
  logic wrote_q;
  logic busy_q;
  logic [BW-1:0] busy_cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] mem_q [0:MEM_BYTES-1];

  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic addr_match;
  logic mem_we;
  logic [DATA_W-1:0] cur_byte;

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Straps are pins too, so they get synchronised
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_meta_q <= '0;
      sel_q <= '0;
    end else begin
      sel_meta_q <= chip_select_straps;
      sel_q <= sel_meta_q;
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign rise = scl_s & ~scl_prev_q;
  assign fall = ~scl_s & scl_prev_q;
  assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign byte_done = fall && (bit_q == BITS_PER_BYTE);
  assign addr_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == sel_q);
  assign cur_byte = mem_q[addr_q];

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= D_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      hi_q <= '0;
      byte_idx_q <= '0;
      rw_q <= RW_WRITE;
      oe_q <= 1'b0;
      wrote_q <= 1'b0;
      addr_q <= '0;
    end else if (busy_q) begin
      // Deaf until the write cycle is over
      state_q <= D_IDLE;
      oe_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (start_seen) begin
      // Repeated start lands here too, counter untouched
      state_q <= D_ADDR;
      bit_q <= '0;
      oe_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= D_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (state_q)
        D_ADDR: begin
          if (rise) begin
            shift_q <= {shift_q[DATA_W-2:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (byte_done) begin
            if (addr_match) begin
              oe_q <= 1'b1;
              rw_q <= shift_q[0];
              byte_idx_q <= '0;
              state_q <= D_ACK;
            end else begin
              state_q <= D_IDLE;
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            bit_q <= '0;
            if (rw_q == RW_READ) begin
              shift_q <= cur_byte;
              oe_q <= ~cur_byte[DATA_W-1];
              state_q <= D_TX;
            end else begin
              oe_q <= 1'b0;
              state_q <= D_WRX;
            end
          end
        end
        D_WRX: begin
          if (rise) begin
            shift_q <= {shift_q[DATA_W-2:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (byte_done) begin
            oe_q <= 1'b1;
            state_q <= D_ACK;
            if (byte_idx_q == 2'h0) begin
              hi_q <= shift_q;
              byte_idx_q <= 2'h1;
            end else if (byte_idx_q == 2'h1) begin
              addr_q <= {hi_q, shift_q};
              byte_idx_q <= 2'h2;
            end else begin
              // Page roll: only the low bits move on writes
              addr_q <= {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 7'h1};
              wrote_q <= 1'b1;
            end
          end
        end
        D_TX: begin
          if (rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (fall) begin
            if (bit_q == BITS_PER_BYTE) begin
              oe_q <= 1'b0;
              state_q <= D_MACK;
            end else begin
              shift_q <= {shift_q[DATA_W-2:0], 1'b0};
              oe_q <= ~shift_q[DATA_W-2];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            // Natural 16-bit overflow gives the wrap to zero
            addr_q <= addr_q + 16'h1;
            if (sda_s != ACK_BIT) begin
              state_q <= D_IDLE;
            end
          end else if (fall) begin
            shift_q <= cur_byte;
            oe_q <= ~cur_byte[DATA_W-1];
            bit_q <= '0;
            state_q <= D_TX;
          end
        end
        default: begin
          state_q <= D_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Array; no reset, contents survive bus traffic
  // ----------------------------------------
  assign mem_we = !busy_q && !start_seen && !stop_seen && (state_q == D_WRX) && byte_done && (byte_idx_q == 2'h2);

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[addr_q] <= shift_q;
    end
  end

  // ----------------------------------------
  // Internal write cycle timer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (!busy_q && stop_seen && wrote_q) begin
      busy_q <= 1'b1;
      busy_cnt_q <= BW'(TWR_CYC - 1);
    end else if (busy_q) begin
      if (busy_cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_q;
  assign write_busy = busy_q;
  // Counter persists; only reset clears it
  assign word_addr = addr_q;

endmodule : sre_target
`default_nettype wire

// ### src/sre_controller.sv
`timescale 1ns/10ps
`default_nettype none
module sre_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic full_q;
  // Valid kept as its own flop so the output needs no inverter
  logic valid_q;
  logic push;
  logic pop;
  logic [AW:0] cnt_d;

  assign push = in_valid & ~full_q;
  assign pop = out_ready & valid_q;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      wr_q <= (push && wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(push);
      rd_q <= (pop && rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(pop);
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (AW + 1)'(DEPTH));
      valid_q <= (cnt_d != '0);
    end
  end

  assign in_ready = ~full_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[rd_q];
endmodule : sre_fifo

module sre_controller #(
  parameter int QTR = sre_pkg::QTR_CYCLES,
  parameter int DEPTH = sre_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  sre_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_random,
  input wire logic [sre_pkg::SEL_W-1:0] cmd_select,
  input wire logic [sre_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [sre_pkg::ADDR_W-1:0] cmd_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sre_pkg::DATA_W-1:0] rd_data,
  output logic done,
  output logic nack_seen
);
  import sre_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_TX,
    H_RACK,
    H_RX,
    H_PUSH,
    H_MACK,
    H_STOP
  } sre_hstate_t;

  typedef enum logic [1:0] {
    ST_DW,
    ST_AH,
    ST_AL,
    ST_DR
  } sre_stage_t;

  localparam int QW = $clog2(QTR);

  sre_hstate_t state_q;
  sre_stage_t stage_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [DATA_W-1:0] tx_q;
  logic [DATA_W-1:0] rx_q;
  logic [SEL_W-1:0] sel_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] left_q;
  logic [1:0] sda_sync_q;
  logic samp_q;
  logic scl_q;
  logic low_q;
  logic ready_q;
  logic done_q;
  logic nack_q;
  logic scl_d;
  logic low_d;
  logic tick;
  logic slot_end;
  logic fifo_ready;

  // ----------------------------------------
  // Bit slot timing; stalls while waiting on the FIFO
  // ----------------------------------------
  assign tick = (qcnt_q == QW'(QTR - 1));
  assign slot_end = tick && (ph_q == 2'h3);

  always_ff @(posedge clk) begin
    if (!resetn || state_q == H_IDLE || state_q == H_PUSH) begin
      qcnt_q <= '0;
      ph_q <= '0;
    end else begin
      qcnt_q <= tick ? '0 : qcnt_q + 1'b1;
      ph_q <= tick ? ph_q + 2'h1 : ph_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sda_sync_q <= 2'h3;
      samp_q <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      if (tick && ph_q == 2'h2) begin
        samp_q <= sda_sync_q[1];
      end
    end
  end

  // ----------------------------------------
  // Pin waveform per slot phase
  // ----------------------------------------
  always_comb begin
    scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
    low_d = 1'b0;
    case (state_q)
      H_IDLE: scl_d = 1'b1;
      H_PUSH: scl_d = 1'b0;
      H_START: low_d = ph_q[1];
      H_TX: low_d = ~tx_q[DATA_W-1];
      H_MACK: low_d = (left_q != '0);
      H_STOP: begin
        scl_d = (ph_q != 2'h0);
        low_d = ~ph_q[1];
      end
      default: low_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      low_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      low_q <= low_d;
    end
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= H_IDLE;
      stage_q <= ST_DR;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      sel_q <= '0;
      addr_q <= '0;
      left_q <= '0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (cmd_valid && ready_q) begin
            ready_q <= 1'b0;
            nack_q <= 1'b0;
            sel_q <= cmd_select;
            addr_q <= cmd_addr;
            left_q <= cmd_len;
            stage_q <= cmd_random ? ST_DW : ST_DR;
            state_q <= H_START;
          end
        end
        H_START: begin
          if (slot_end) begin
            tx_q <= {DEV_TYPE, sel_q, (stage_q == ST_DW) ? RW_WRITE : RW_READ};
            bit_q <= '0;
            state_q <= H_TX;
          end
        end
        H_TX: begin
          if (slot_end) begin
            tx_q <= {tx_q[DATA_W-2:0], 1'b0};
            bit_q <= bit_q + 3'h1;
            state_q <= (bit_q == LAST_BIT) ? H_RACK : H_TX;
          end
        end
        H_RACK: begin
          if (slot_end) begin
            bit_q <= '0;
            if (samp_q != ACK_BIT) begin
              nack_q <= 1'b1;
              state_q <= H_STOP;
            end else begin
              case (stage_q)
                ST_DW: begin
                  tx_q <= addr_q[ADDR_W-1:DATA_W];
                  stage_q <= ST_AH;
                  state_q <= H_TX;
                end
                ST_AH: begin
                  tx_q <= addr_q[DATA_W-1:0];
                  stage_q <= ST_AL;
                  state_q <= H_TX;
                end
                ST_AL: begin
                  stage_q <= ST_DR;
                  state_q <= H_START;
                end
                default: state_q <= H_RX;
              endcase
            end
          end
        end
        H_RX: begin
          if (slot_end) begin
            rx_q <= {rx_q[DATA_W-2:0], samp_q};
            bit_q <= bit_q + 3'h1;
            state_q <= (bit_q == LAST_BIT) ? H_PUSH : H_RX;
          end
        end
        H_PUSH: begin
          // SCL held low until the FIFO has room
          if (fifo_ready) begin
            left_q <= left_q - 16'h1;
            state_q <= H_MACK;
          end
        end
        H_MACK: begin
          if (slot_end) begin
            state_q <= (left_q == '0) ? H_STOP : H_RX;
          end
        end
        H_STOP: begin
          if (slot_end) begin
            done_q <= 1'b1;
            ready_q <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  sre_fifo #(.W(DATA_W), .DEPTH(DEPTH)) i_sre_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(state_q == H_PUSH),
    .in_ready(fifo_ready),
    .in_data(rx_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign bus.scl = scl_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = low_q;
  assign cmd_ready = ready_q;
  assign done = done_q;
  assign nack_seen = nack_q;
endmodule : sre_controller
`default_nettype wire

// ### tb/sre_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sre_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  import sre_pkg::*;

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // Framing follows the controller's enable, not sda: read data may be unknown
  logic scl_q;
  logic hoe_q;
  logic in_frame_q;
  logic acked_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] addr_q;
  logic rise;
  logic start;
  logic stop;

  assign rise = scl && !scl_q;
  assign start = scl && scl_q && host_sda_oe && !hoe_q;
  assign stop = scl && scl_q && !host_sda_oe && hoe_q;

  always_ff @(posedge clk) begin
    scl_q <= resetn ? scl : 1'b1;
    hoe_q <= resetn ? host_sda_oe : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!resetn || stop) begin
      in_frame_q <= 1'b0;
    end else if (start) begin
      in_frame_q <= 1'b1;
    end
  end

  // Byte count saturates; only the first few bytes matter here
  always_ff @(posedge clk) begin
    if (!resetn || start) begin
      bit_q <= 4'h0;
      byte_q <= 3'h0;
    end else if (rise) begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'h8 && byte_q != 3'h7) begin
        byte_q <= byte_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || start) begin
      addr_q <= resetn ? addr_q : 8'h00;
      acked_q <= 1'b0;
    end else if (rise && byte_q == 3'h0) begin
      if (bit_q < 4'h8) begin
        addr_q <= {addr_q[6:0], !host_sda_oe};
      end else begin
        acked_q <= dev_sda_oe;
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_idle;
    $rose(resetn) |-> scl && sda && !host_sda_oe && !dev_sda_oe && !host_sda_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");

  property p_quiet_outside;
    !in_frame_q |-> !dev_sda_oe && !dev_sda_o;
  endproperty
  a_quiet_outside: assert property (p_quiet_outside) else $error("target drives outside a frame");

  property p_addr_quiet;
    in_frame_q && byte_q == 3'h0 && bit_q < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("target drives during address byte");

  property p_ack_type;
    in_frame_q && byte_q == 3'h0 && dev_sda_oe |-> bit_q == 4'h8 && addr_q[7:4] == DEV_TYPE;
  endproperty
  a_ack_type: assert property (p_ack_type) else $error("ack for a foreign address");

  property p_ack_held;
    rise && in_frame_q && byte_q == 3'h0 && bit_q == 4'h8 && dev_sda_oe |-> dev_sda_oe [*8];
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("address ack dropped while scl high");

  property p_word_addr_ack;
    rise && in_frame_q && acked_q && addr_q[0] == RW_WRITE && byte_q inside {3'h1, 3'h2} && bit_q == 4'h8
      |-> dev_sda_oe;
  endproperty
  a_word_addr_ack: assert property (p_word_addr_ack) else $error("word address byte not acked");

  property p_host_releases;
    rise && in_frame_q && acked_q && addr_q[0] == RW_READ && byte_q != 3'h0 && bit_q inside {[4'h1:4'h7]}
      |-> !host_sda_oe;
  endproperty
  a_host_releases: assert property (p_host_releases) else $error("controller drives during read data");

  property p_dev_free_at_ack;
    rise && in_frame_q && acked_q && addr_q[0] == RW_READ && byte_q != 3'h0 && bit_q == 4'h8 |-> !dev_sda_oe;
  endproperty
  a_dev_free_at_ack: assert property (p_dev_free_at_ack) else $error("target holds sda in ack slot");

  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
endmodule : sre_sva
`default_nettype wire

// ### tb/serial_eeprom_read_engine_bench.sv
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_engine_bench;
  import sre_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [2:0] STRAPS = 3'h5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_random = 1'b0;
  logic [2:0] cmd_select = 3'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_len = 16'h0001;
  logic rd_ready = 1'b0;
  logic cmd_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic done;
  logic nack_seen;
  logic write_busy;
  logic [15:0] word_addr;
  logic [15:0] pops;
  logic [15:0] dones;
  int n_mismatch = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  sre_if bus_if ();

  // Short write timer keeps any write cycle cheap in simulation
  sre_target #(.TWR_CYC(50)) i_sre_target (.clk(clk), .resetn(resetn), .bus(bus_if),
    .chip_select_straps(STRAPS), .write_busy(write_busy), .word_addr(word_addr));

  sre_controller #(.QTR(8), .DEPTH(FIFO_DEPTH)) i_sre_controller (.clk(clk), .resetn(resetn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random), .cmd_select(cmd_select),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .nack_seen(nack_seen));

  sre_sva i_sre_sva (.clk(clk), .resetn(resetn), .scl(bus_if.scl), .sda(bus_if.sda),
    .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Stall of 0 pops at once; otherwise the FIFO fills and scl is held
  task automatic read_cmd(input logic rnd, input logic [2:0] sel, input logic [15:0] addr,
      input logic [15:0] len, input int stall, input logic [15:0] stall_addr);
    int i;
    pops = 16'h0;
    dones = 16'h0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_random = rnd;
    cmd_select = sel;
    cmd_addr = addr;
    cmd_len = len;
    rd_ready = 1'b0;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 50) begin
      n_mismatch++;
      finish_test;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 40000; i++) begin
      @(negedge clk);
      if (i == stall) begin
        if (stall > 0) check("held word address", word_addr, stall_addr);
        rd_ready = 1'b1;
      end
      if (rd_valid === 1'b1 && rd_ready === 1'b1) pops++;
      if (done === 1'b1) dones++;
      if (dones != 16'h0 && rd_valid === 1'b0) break;
    end
    if (i == 40000) begin
      n_mismatch++;
      finish_test;
    end
  endtask : read_cmd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check("reset word address", word_addr, 16'h0000);
    check("reset ready", {15'h0, cmd_ready}, 16'h0001);
    read_cmd(1'b1, STRAPS, 16'hfffa, 16'd10, 6000, 16'h0002);
    check("wrapped byte count", pops, 16'd10);
    check("wrapped done count", dones, 16'd1);
    check("wrapped address", word_addr, 16'h0004);
    check("busy after dummy write", {15'h0, write_busy}, 16'h0000);
    read_cmd(1'b0, STRAPS, 16'h0000, 16'd1, 0, 16'h0000);
    check("single byte count", pops, 16'd1);
    check("single read address", word_addr, 16'h0005);
    repeat (200) @(negedge clk);
    check("idle address kept", word_addr, 16'h0005);
    read_cmd(1'b0, STRAPS, 16'h0000, 16'd3, 0, 16'h0000);
    check("sequential byte count", pops, 16'd3);
    check("sequential address", word_addr, 16'h0008);
    read_cmd(1'b1, 3'h2, 16'h1234, 16'd2, 0, 16'h0000);
    check("foreign select nack", {15'h0, nack_seen}, 16'h0001);
    check("foreign select bytes", pops, 16'd0);
    check("foreign select address", word_addr, 16'h0008);
    read_cmd(1'b1, STRAPS, 16'hffff, 16'd2, 0, 16'h0000);
    check("nack cleared", {15'h0, nack_seen}, 16'h0000);
    check("top random bytes", pops, 16'd2);
    check("top random address", word_addr, 16'h0001);
    finish_test;
  end
endmodule : serial_eeprom_read_engine_bench
`default_nettype wire
